/* File: design/serial_port_pkg.sv */
// constants and types shared by the serial port design
package serial_port_pkg;

  // register indices; byte address is four times the index
  localparam logic [7:0] CONTROL_IDX = 8'hb5;
  localparam logic [7:0] DATA_IDX    = 8'hb6;
  localparam logic [7:0] STATUS_IDX  = 8'hb7;

  // reset values
  localparam logic [7:0] CONTROL_RST = 8'h00;
  localparam logic [7:0] DATA_RST    = 8'h00;
  localparam logic [7:0] STATUS_RST  = 8'h00;

  // control field positions
  localparam int CTL_ENABLE = 7;
  localparam int CTL_LSB    = 6;
  localparam int CTL_MASTER = 5;
  localparam int CTL_CPOL   = 4;
  localparam int CTL_CPHA   = 3;
  localparam int CTL_DOUBLE = 2;
  localparam int CTL_RATE   = 0;

  // status field positions
  localparam int STS_DONE   = 7;
  localparam int STS_WRITE_COLLISION_FLAG   = 6;
  localparam int STS_SSHIGH = 5;
  localparam int STS_SWAP   = 3;
  localparam int STS_SELECT_PIN_ENABLE  = 2;

  // bits per byte and index of the last clock edge of a byte
  localparam logic [3:0] BITS_PER_BYTE  = 4'h8;
  localparam logic [3:0] LAST_HALF_EDGE = 4'hf;

  // half serial clock periods in system clocks, by rate code
  localparam logic [7:0] HALF_DIV4   = 8'h02;
  localparam logic [7:0] HALF_DIV16  = 8'h08;
  localparam logic [7:0] HALF_DIV64  = 8'h20;
  localparam logic [7:0] HALF_DIV128 = 8'h40;
  localparam logic [7:0] HALF_DIV2   = 8'h01;
  localparam logic [7:0] HALF_DIV8   = 8'h04;
  localparam logic [7:0] HALF_DIV32  = 8'h10;

  // control register layout
  typedef struct packed {
    logic       enable;
    logic       lsb_first;
    logic       master;
    logic       cpol;
    logic       cpha;
    logic       double_rate;
    logic [1:0] rate;
  } ctrl_t;

  // one driven pin: level and active-low enable
  typedef struct packed {
    logic o;
    logic oe_n;
  } pin_out_t;

  // transfer engine states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_MRUN = 3'b010,
    ST_SRUN = 3'b100
  } xfer_state_t;

endpackage

/* File: design/pin_sync.sv */
// two-flop synchroniser for pins from outside the clock domain
`timescale 1ns/100ps
module pin_sync #(
  parameter int WIDTH = 4
) (
  // clock and reset
  input  wire logic             hclk,
  input  wire logic             hresetn,
  // raw and synchronised levels
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] meta_nxt;
  logic [WIDTH-1:0] sync_nxt;

  // second stage only reads the first
  always_comb begin
    meta_nxt = async_in;
    sync_nxt = meta_r;
  end

  // register both stages
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      meta_r   <= '0;
      sync_out <= '0;
    end else begin
      meta_r   <= meta_nxt;
      sync_out <= sync_nxt;
    end
  end

endmodule

/* File: design/half_period_divider.sv */
// divider giving one enable pulse per serial clock half period
`timescale 1ns/100ps
module half_period_divider
  import serial_port_pkg::*;
(
  // clock and reset
  input  wire logic       hclk,
  input  wire logic       hresetn,
  // control
  input  wire logic       run,
  input  wire logic [2:0] rate_sel,
  // enable pulse
  output logic            tick
);

  logic [7:0] count_r;
  logic [7:0] count_nxt;
  logic [7:0] half_len;

  // half period length for a rate code
  function automatic logic [7:0] half_cycles(input logic [2:0] sel);
    case (sel)
      3'h0:    half_cycles = HALF_DIV4;
      3'h1:    half_cycles = HALF_DIV16;
      3'h2:    half_cycles = HALF_DIV64;
      3'h3:    half_cycles = HALF_DIV128;
      3'h4:    half_cycles = HALF_DIV2;
      3'h5:    half_cycles = HALF_DIV8;
      3'h6:    half_cycles = HALF_DIV32;
      default: half_cycles = HALF_DIV32;
    endcase
  endfunction

  // count up to the half period, restart when stopped
  always_comb begin
    half_len  = half_cycles(rate_sel);
    tick      = run && (count_r == half_len - 8'h01);
    count_nxt = count_r + 8'h01;
    if (!run || tick) begin
      count_nxt = 8'h00;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count_r <= 8'h00;
    end else begin
      count_r <= count_nxt;
    end
  end

endmodule

/* File: design/spi_serial_port.sv */
// serial peripheral port: ahb-lite registers, master and slave engine
// Summary of operation
// - full duplex bytes on four wires, master or slave, polarity, phase, order
// - writing the data register starts a byte transfer
// - master drives serial clock, shifting eight bits out and in together
// - byte completion sets the done flag and requests interrupt if enabled
// - with interrupt enabled, acknowledge clears the done flag
// - with interrupt disabled, status read then data access clears the flag
// - select is active low; master selects slave, slave is chosen externally
// - in slave mode select is an input and low activates the logic
// - select high in slave mode resets logic and drops partial data
// - master seeing select low becomes slave and sets the done flag; done is not set when the fault occurs in ST_SRUN
// - select as output in master mode follows the general port value
// - select disabled: pin free, internal select high for master, low slave
// - select input high sets the select-high flag, cleared by writing zero
// - polarity sets idle level; phase picks sample and setup edges
// - enable bit switches the port on and off
// - master bit selects master mode, clear gives slave mode
//
// Design decision made here: register access over AHB-Lite.
`timescale 1ns/100ps
module spi_serial_port
  import serial_port_pkg::*;
(
  // clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // interrupt controller side
  input  wire logic        int_enable,
  input  wire logic        int_ack,
  output logic             irq_req,
  // general port for the select pin
  input  wire logic        select_port_direction,
  input  wire logic        select_port_value,
  // serial clock pin
  input  wire logic        serial_clock_pin_in,
  output pin_out_t         serial_clock_pin,
  // master out data pin
  input  wire logic        master_out_pin_in,
  output pin_out_t         master_out_pin,
  // master in data pin
  input  wire logic        master_in_pin_in,
  output pin_out_t         master_in_pin,
  // select pin
  input  wire logic        slave_select_pin_in,
  output pin_out_t         slave_select_pin
);

  // register group
  ctrl_t       ctrl_r, ctrl_nxt;
  logic [7:0]  data_r, data_nxt;
  logic        done_r, done_nxt;
  logic        write_collision_flag_r, write_collision_flag_nxt;
  logic        sshigh_r, sshigh_nxt;
  logic        swap_r, swap_nxt;
  logic        select_pin_enable_r, select_pin_enable_nxt;
  logic        armed_r, armed_nxt;
  logic        wr_pend_r, wr_pend_nxt;
  logic [7:0]  widx_r, widx_nxt;
  logic [31:0] rdata_nxt;
  // engine group
  xfer_state_t state_r, state_nxt;
  logic [7:0]  tx_r, tx_nxt;
  logic [7:0]  rx_r, rx_nxt;
  logic [3:0]  hcnt_r, hcnt_nxt;
  logic [3:0]  cnt_r, cnt_nxt;
  logic        sck_r, sck_nxt;
  logic        first_r, first_nxt;
  logic        sck_prev_r;
  // synchronised pins and helpers
  logic [3:0]  pins_s;
  logic        sck_s, mo_s, mi_s, ss_s;
  logic        tick, accept, data_wr, data_rd, stat_rd;
  logic        collide, load, xfer_done, mode_fault;
  logic        ss_is_input, sel_int, slave_on, busy;
  logic        lead_ev, trail_ev, sample_ev, setup_ev, rx_bit, tx_bit;
  logic        mdrive, sdrive;

  // shift one received bit in, order per control
  function automatic logic [7:0] shift_in(input logic [7:0] v, input logic b,
                                          input logic lsb);
    shift_in = lsb ? {b, v[7:1]} : {v[6:0], b};
  endfunction

  // shift the transmit byte by one place
  function automatic logic [7:0] shift_out(input logic [7:0] v, input logic lsb);
    shift_out = lsb ? {1'b0, v[7:1]} : {v[6:0], 1'b0};
  endfunction

  pin_sync #(
    .WIDTH    (4)
  ) u_sync (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .async_in ({serial_clock_pin_in, master_out_pin_in, master_in_pin_in,
                slave_select_pin_in}),
    .sync_out (pins_s)
  );

  assign sck_s = pins_s[3];
  assign mo_s  = pins_s[2];
  assign mi_s  = pins_s[1];
  assign ss_s  = pins_s[0];

  half_period_divider u_div (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .run      (state_r == ST_MRUN),
    .rate_sel ({ctrl_r.double_rate, ctrl_r.rate}),
    .tick     (tick)
  );

  // bus decode; the slave never stalls
  always_comb begin
    hreadyout = 1'b1;
    hresp     = 1'b0;
    accept    = hsel && hready && htrans[1];
    stat_rd   = accept && !hwrite && haddr[9:2] == STATUS_IDX;
    data_rd   = accept && !hwrite && haddr[9:2] == DATA_IDX;
    data_wr   = wr_pend_r && widx_r == DATA_IDX;
  end

  // select handling and pin roles
  always_comb begin
    ss_is_input = select_pin_enable_r && !select_port_direction;
    sel_int     = select_pin_enable_r ? ss_s : ctrl_r.master;
    slave_on    = ctrl_r.enable && !ctrl_r.master && !sel_int;
    mode_fault  = ctrl_r.enable && ctrl_r.master && ss_is_input && !ss_s;
    busy        = state_r == ST_MRUN || (state_r == ST_SRUN && cnt_r != 4'h0);
    collide     = data_wr && busy;
    load        = data_wr && !busy;
    mdrive      = ctrl_r.enable && ctrl_r.master;
    sdrive      = slave_on;
  end

  // edge events from own divider or from the far clock
  always_comb begin
    lead_ev  = 1'b0;
    trail_ev = 1'b0;
    if (state_r == ST_MRUN) begin
      lead_ev  = tick && !hcnt_r[0];
      trail_ev = tick && hcnt_r[0];
    end else if (state_r == ST_SRUN) begin
      lead_ev  = sck_s != sck_prev_r && sck_s != ctrl_r.cpol;
      trail_ev = sck_s != sck_prev_r && sck_s == ctrl_r.cpol;
    end
    sample_ev = ctrl_r.cpha ? trail_ev : lead_ev;
    setup_ev  = ctrl_r.cpha ? (lead_ev && !first_r) : trail_ev;
    rx_bit    = (ctrl_r.master ^ swap_r) ? mi_s : mo_s;
    tx_bit    = ctrl_r.lsb_first ? tx_r[0] : tx_r[7];
  end

  // transfer engine next state
  always_comb begin
    state_nxt = state_r;
    tx_nxt    = tx_r;
    rx_nxt    = rx_r;
    hcnt_nxt  = hcnt_r;
    cnt_nxt   = cnt_r;
    sck_nxt   = sck_r;
    first_nxt = first_r;
    xfer_done = 1'b0;
    if (load) begin
      tx_nxt = data_wr_byte();
    end
    if (sample_ev) begin
      rx_nxt  = shift_in(rx_r, rx_bit, ctrl_r.lsb_first);
      cnt_nxt = cnt_r + 4'h1;
    end
    if (setup_ev) begin
      tx_nxt = shift_out(tx_r, ctrl_r.lsb_first);
    end
    if (lead_ev) begin
      first_nxt = 1'b0;
    end
    case (state_r)
      ST_IDLE: begin
        sck_nxt   = ctrl_r.cpol;
        hcnt_nxt  = 4'h0;
        cnt_nxt   = 4'h0;
        first_nxt = 1'b1;
        if (load && ctrl_r.enable && ctrl_r.master && !mode_fault) begin
          state_nxt = ST_MRUN;
        end else if (slave_on) begin
          state_nxt = ST_SRUN;
        end
      end
      ST_MRUN: begin
        if (tick) begin
          sck_nxt  = !sck_r;
          hcnt_nxt = hcnt_r + 4'h1;
        end
        if (tick && hcnt_r == LAST_HALF_EDGE) begin
          xfer_done = 1'b1;
          state_nxt = ST_IDLE;
        end
        if (mode_fault || !ctrl_r.enable) begin
          xfer_done = mode_fault;
          state_nxt = ST_IDLE;
        end
      end
      ST_SRUN: begin
        if (sample_ev && cnt_r == BITS_PER_BYTE - 4'h1) begin
          xfer_done = 1'b1;
          cnt_nxt   = 4'h0;
          first_nxt = 1'b1;
        end
        if (!slave_on) begin
          state_nxt = ST_IDLE;
          cnt_nxt   = 4'h0;
          rx_nxt    = 8'h00;
          xfer_done = 1'b0;
          // next selection restarts from the stored byte
          tx_nxt    = load ? data_wr_byte() : data_r;
        end
      end
      default: state_nxt = ST_IDLE;
    endcase
    if (state_r == ST_IDLE && mode_fault) begin
      xfer_done = 1'b1;
    end
  end

  // write data of the pending bus write
  function automatic logic [7:0] data_wr_byte();
    data_wr_byte = hwdata[7:0];
  endfunction

  // register file next state
  always_comb begin
    ctrl_nxt    = ctrl_r;
    data_nxt    = data_r;
    done_nxt    = done_r;
    write_collision_flag_nxt    = write_collision_flag_r;
    sshigh_nxt  = sshigh_r;
    swap_nxt    = swap_r;
    select_pin_enable_nxt   = select_pin_enable_r;
    armed_nxt   = armed_r;
    wr_pend_nxt = accept && hwrite;
    widx_nxt    = accept ? haddr[9:2] : widx_r;
    rdata_nxt   = 32'h0000_0000;
    if (stat_rd) begin
      armed_nxt = 1'b1;
    end
    if (armed_r && (data_rd || data_wr)) begin
      done_nxt  = 1'b0;
      write_collision_flag_nxt  = 1'b0;
      armed_nxt = 1'b0;
    end
    if (int_enable && int_ack) begin
      done_nxt = 1'b0;
    end
    if (wr_pend_r) begin
      case (widx_r)
        CONTROL_IDX: ctrl_nxt = ctrl_t'(hwdata[7:0]);
        STATUS_IDX: begin
          if (!hwdata[STS_SSHIGH]) begin
            sshigh_nxt = 1'b0;
          end
          swap_nxt  = hwdata[STS_SWAP];
          select_pin_enable_nxt = hwdata[STS_SELECT_PIN_ENABLE];
        end
        DATA_IDX: if (!busy) data_nxt = hwdata[7:0];
        default: ;
      endcase
    end
    if (mode_fault) begin
      ctrl_nxt.master = 1'b0;
    end
    if (xfer_done) begin
      done_nxt = 1'b1;
      // only take the pin when the last sample lands on this edge
      if (state_r != ST_IDLE && !mode_fault) begin
        data_nxt = sample_ev ? shift_in(rx_r, rx_bit, ctrl_r.lsb_first) : rx_r;
      end
    end
    if (collide) begin
      write_collision_flag_nxt = 1'b1;
    end
    if (ss_is_input && ss_s) begin
      sshigh_nxt = 1'b1;
    end
    if (accept && !hwrite) begin
      case (haddr[9:2])
        CONTROL_IDX: rdata_nxt = {24'h00_0000, ctrl_r};
        DATA_IDX:    rdata_nxt = {24'h00_0000, data_r};
        STATUS_IDX: begin
          rdata_nxt[STS_DONE]   = done_r;
          rdata_nxt[STS_WRITE_COLLISION_FLAG]   = write_collision_flag_r;
          rdata_nxt[STS_SSHIGH] = sshigh_r;
          rdata_nxt[STS_SWAP]   = swap_r;
          rdata_nxt[STS_SELECT_PIN_ENABLE]  = select_pin_enable_r;
        end
        default:     rdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  // register both groups
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_r     <= ctrl_t'(CONTROL_RST);
      data_r     <= DATA_RST;
      {done_r, write_collision_flag_r, sshigh_r} <= 3'h0;
      swap_r     <= STATUS_RST[STS_SWAP];
      select_pin_enable_r    <= STATUS_RST[STS_SELECT_PIN_ENABLE];
      armed_r    <= 1'b0;
      wr_pend_r  <= 1'b0;
      widx_r     <= 8'h00;
      hrdata     <= 32'h0000_0000;
      state_r    <= ST_IDLE;
      tx_r       <= 8'h00;
      rx_r       <= 8'h00;
      hcnt_r     <= 4'h0;
      cnt_r      <= 4'h0;
      sck_r      <= 1'b0;
      first_r    <= 1'b1;
      sck_prev_r <= 1'b0;
    end else begin
      ctrl_r     <= ctrl_nxt;
      data_r     <= data_nxt;
      done_r     <= done_nxt;
      write_collision_flag_r     <= write_collision_flag_nxt;
      sshigh_r   <= sshigh_nxt;
      swap_r     <= swap_nxt;
      select_pin_enable_r    <= select_pin_enable_nxt;
      armed_r    <= armed_nxt;
      wr_pend_r  <= wr_pend_nxt;
      widx_r     <= widx_nxt;
      hrdata     <= rdata_nxt;
      state_r    <= state_nxt;
      tx_r       <= tx_nxt;
      rx_r       <= rx_nxt;
      hcnt_r     <= hcnt_nxt;
      cnt_r      <= cnt_nxt;
      sck_r      <= sck_nxt;
      first_r    <= first_nxt;
      sck_prev_r <= sck_s;
    end
  end

  // pin drivers, enables active low
  always_comb begin
    irq_req               = done_r && int_enable;
    serial_clock_pin.o    = (mdrive && state_r == ST_MRUN) ? sck_r : ctrl_r.cpol;
    serial_clock_pin.oe_n = !mdrive;
    master_out_pin.o      = tx_bit;
    master_out_pin.oe_n   = !((mdrive && !swap_r) || (sdrive && swap_r));
    master_in_pin.o       = tx_bit;
    master_in_pin.oe_n    = !((mdrive && swap_r) || (sdrive && !swap_r));
    slave_select_pin.o    = select_port_value;
    slave_select_pin.oe_n = !select_port_direction
                            || (select_pin_enable_r && ctrl_r.enable && !ctrl_r.master);
  end

endmodule

/* File: verif/spi_serial_port_checker.sv */
// port-level assertions for the serial port
`timescale 1ns/100ps
module spi_serial_port_checker
  import serial_port_pkg::*;
(
  // clock and reset
  input wire logic        hclk,
  input wire logic        hresetn,
  // register bus
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [31:0] hrdata,
  // interrupt side
  input wire logic        int_enable,
  input wire logic        int_ack,
  input wire logic        irq_req,
  // pins
  input wire logic        select_port_direction,
  input wire logic        select_port_value,
  input wire pin_out_t    serial_clock_pin,
  input wire pin_out_t    slave_select_pin
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic [4:0] tog_r;
  logic [4:0] tog_nxt;
  logic       clk_q_r;

  // count driven clock toggles since the last data write
  always_comb begin
    tog_nxt = tog_r;
    if (hsel && htrans[1] && hwrite && haddr[9:2] == DATA_IDX) begin
      tog_nxt = 5'h00;
    end else if (!serial_clock_pin.oe_n && serial_clock_pin.o != clk_q_r) begin
      tog_nxt = tog_r + 5'h01;
    end
  end

  // toggle counter registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tog_r   <= 5'h00;
      clk_q_r <= 1'b0;
    end else begin
      tog_r   <= tog_nxt;
      clk_q_r <= serial_clock_pin.o;
    end
  end

  a_resp_okay: assert property (hresp == 1'b0)
    else $error("bus response not okay");
  a_ready_high: assert property (hreadyout == 1'b1)
    else $error("slave inserted a wait state");
  a_rdata_upper: assert property (hrdata[31:8] == 24'h000000)
    else $error("read data upper lanes not zero");
  a_irq_gated: assert property (!int_enable |-> !irq_req)
    else $error("request raised while disabled");
  a_ack_clears: assert property (int_enable && int_ack ##1 int_enable |-> !irq_req)
    else $error("acknowledge left the request up");
  a_sel_follow: assert property (select_port_direction && !slave_select_pin.oe_n
    |-> slave_select_pin.o == select_port_value)
    else $error("select pin not following port value");
  a_clk_edges: assert property ($rose(irq_req) && !serial_clock_pin.oe_n
    |-> tog_nxt == 5'h10)
    else $error("master clock toggle count wrong");
  a_clk_idle: assert property ($rose(irq_req) && !serial_clock_pin.oe_n
    |=> $stable(serial_clock_pin.o) [*4])
    else $error("clock moved after byte end");
endmodule

bind spi_serial_port spi_serial_port_checker chk_u (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
  .int_enable(int_enable), .int_ack(int_ack), .irq_req(irq_req),
  .select_port_direction(select_port_direction), .select_port_value(select_port_value),
  .serial_clock_pin(serial_clock_pin), .slave_select_pin(slave_select_pin));

/* File: verif/spi_far_slave.sv */
// behavioural far-side slave on the serial link
`timescale 1ns/100ps
module spi_far_slave (
  // link wires
  input  wire logic       sclk,
  input  wire logic       mosi,
  input  wire logic       sel_n,
  // mode and reply
  input  wire logic       cpol,
  input  wire logic       cpha,
  input  wire logic       lsb,
  input  wire logic [7:0] tx_byte,
  // reply line and received byte
  output logic            miso,
  output logic [7:0]      rx_byte,
  output logic            rx_full
);
  int   k = 0;
  int   idx;

  always @(posedge sel_n) begin
    k = 0;
    rx_full = 1'b0;
  end

  // sample and shift on link edges
  always @(sclk) begin
    if (!sel_n && k < 16) begin
      if ((sclk != cpol) ^ cpha) begin
        rx_byte = lsb ? {mosi, rx_byte[7:1]} : {rx_byte[6:0], mosi};
      end
      k = k + 1;
      rx_full = (k == 16);
    end
  end

  always @(*) begin
    idx = cpha ? (k - 1) >>> 1 : k >>> 1;
    if (sel_n || idx < 0 || idx > 7) begin
      miso = lsb ? ~tx_byte[0] : ~tx_byte[7]; // released: inverse of first bit
    end else begin
      miso = lsb ? tx_byte[idx] : tx_byte[7 - idx];
    end
  end
endmodule

/* File: verif/test_spi_serial_port.sv */
// self-checking bench for the serial port
`timescale 1ns/100ps
module test_spi_serial_port;
  import serial_port_pkg::*;
  logic        hclk = 0, hresetn = 0, hsel = 1, hwrite = 0, hready = 1;
  logic [31:0] haddr = 0, hwdata = 0, hrdata;
  logic [1:0]  htrans = 0;
  logic        int_enable = 0, int_ack = 0, sp_dir = 1, sp_val = 0, part_sel_n = 1;
  logic        ext_clk = 0, ext_mo = 0, ext_ss = 1, p_cpol = 0, p_cpha = 0, p_lsb = 0;
  logic        hreadyout, hresp, irq_req, p_miso, rx_full, rd_ph = 0;
  logic [7:0]  p_tx = 0, tx, rx, v, g, rx_byte;
  logic [15:0] e;
  pin_out_t    sck_o, mo_o, mi_o, ss_o;
  wire         clk_w = sck_o.oe_n ? ext_clk : sck_o.o;
  wire         mo_w = mo_o.oe_n ? ext_mo : mo_o.o;
  wire         mi_w = mi_o.oe_n ? p_miso : mi_o.o;
  wire         ss_w = ss_o.oe_n ? ext_ss : ss_o.o;
  logic [15:0] q[$];
  logic [7:0]  pq[$];
  int          n_errors = 0, checks_done = 0, cyc = 0, seed, n;

  always #20 hclk = ~hclk;

  spi_serial_port dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .int_enable(int_enable),
    .int_ack(int_ack), .irq_req(irq_req), .select_port_direction(sp_dir),
    .select_port_value(sp_val), .serial_clock_pin_in(clk_w), .serial_clock_pin(sck_o),
    .master_out_pin_in(mo_w), .master_out_pin(mo_o), .master_in_pin_in(mi_w),
    .master_in_pin(mi_o), .slave_select_pin_in(ss_w), .slave_select_pin(ss_o));

  spi_far_slave part_u (.sclk(clk_w), .mosi(mo_w), .sel_n(part_sel_n), .cpol(p_cpol),
    .cpha(p_cpha), .lsb(p_lsb), .tx_byte(p_tx), .miso(p_miso), .rx_byte(rx_byte),
    .rx_full(rx_full));

  task bump(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // read data phase against the oldest note
  always @(posedge hclk) begin
    if (rd_ph && q.size() > 0) begin
      e = q.pop_front();
      bump(hrdata[7:0] & e[15:8], e[7:0] & e[15:8]);
    end
    rd_ph <= htrans[1] && !hwrite && hreadyout;
  end

  // byte seen by the far slave
  always @(posedge rx_full) begin
    if (pq.size() > 0) bump(rx_byte, pq.pop_front());
  end

  task wr(input logic [7:0] idx, input logic [7:0] d);
    @(posedge hclk);
    htrans <= 2'b10;
    hwrite <= 1'b1;
    haddr  <= {22'h0, idx, 2'b00};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= {24'h0, d};
    do @(posedge hclk); while (hreadyout !== 1'b1);
  endtask

  task rd(input logic [7:0] idx, input logic [7:0] ex, input logic [7:0] m);
    q.push_back({m, ex});
    @(posedge hclk);
    htrans <= 2'b10;
    hwrite <= 1'b0;
    haddr  <= {22'h0, idx, 2'b00};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    v = hrdata[7:0];
  endtask

  task wait_irq;
    n = 0;
    while (irq_req !== 1'b1 && n < 4000) begin
      @(posedge hclk);
      n++;
    end
    if (n == 4000) n_errors++;
  endtask

  // external master, mode 0, msb first, one half period of four clocks
  task ext_byte(input logic [7:0] d, input int nb);
    ext_ss <= 1'b0;
    ext_mo <= d[7];
    repeat (8) @(posedge hclk);
    for (int i = 0; i < nb; i++) begin
      ext_clk <= 1'b1;
      g = {g[6:0], mi_w};
      repeat (4) @(posedge hclk);
      ext_clk <= 1'b0;
      ext_mo <= (i < 7) ? d[6-i] : ~d[0];
      repeat (4) @(posedge hclk);
    end
    ext_ss <= 1'b1;
  endtask

  task end_of_test;
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // cut a hang short
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      end_of_test;
    end
  end

  initial begin
    seed = 64071;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    rd(CONTROL_IDX, CONTROL_RST, 8'hff);
    rd(DATA_IDX, DATA_RST, 8'hff);
    rd(STATUS_IDX, STATUS_RST, 8'hdf);
    rd(8'h00, 8'h00, 8'hff);
    wr(CONTROL_IDX, 8'h5a);
    rd(CONTROL_IDX, 8'h5a, 8'hff);
    $display("test registers done");
    int_enable <= 1'b1;
    for (int m = 0; m < 8; m++) begin
      p_cpol <= m[0];
      p_cpha <= m[1];
      p_lsb  <= m[2];
      p_tx   <= 8'($random(seed));
      tx = 8'($random(seed));
      wr(CONTROL_IDX, {1'b1, m[2], 1'b1, m[0], m[1], 3'b001});
      @(posedge hclk);
      part_sel_n <= 1'b0;
      pq.push_back(tx);
      wr(DATA_IDX, tx);
      wait_irq;
      rd(DATA_IDX, p_tx, 8'hff);
      int_ack <= 1'b1;
      @(posedge hclk);
      int_ack <= 1'b0;
      part_sel_n <= 1'b1;
      rd(STATUS_IDX, 8'h00, 8'h80);
    end
    $display("test master modes done");
    int_enable <= 1'b0;
    part_sel_n <= 1'b0;
    pq.push_back(8'h3c);
    wr(DATA_IDX, 8'h3c);
    wr(DATA_IDX, 8'hc3);
    n = 0;
    do begin
      rd(STATUS_IDX, 8'h00, 8'h00);
      n++;
    end while (v[7] !== 1'b1 && n < 200);
    rd(STATUS_IDX, 8'hc0, 8'hc0);
    rd(DATA_IDX, p_tx, 8'hff);
    rd(STATUS_IDX, 8'h00, 8'hc0);
    part_sel_n <= 1'b1;
    $display("test collision done");
    wr(CONTROL_IDX, 8'h81);
    sp_dir <= 1'b0;
    wr(STATUS_IDX, 8'h04);
    rd(STATUS_IDX, 8'h20, 8'h20);
    ext_ss <= 1'b0;
    wr(STATUS_IDX, 8'h04);
    rd(STATUS_IDX, 8'h04, 8'h24);
    tx = 8'($random(seed));
    rx = 8'($random(seed));
    wr(DATA_IDX, tx);
    ext_byte(~rx, 3);
    repeat (8) @(posedge hclk);
    ext_byte(rx, 8);
    bump(g, tx);
    rd(STATUS_IDX, 8'h80, 8'h80);
    rd(DATA_IDX, rx, 8'hff);
    $display("test slave done");
    wr(CONTROL_IDX, 8'ha1);
    rd(CONTROL_IDX, 8'ha1, 8'hff);
    ext_ss <= 1'b0;
    repeat (6) @(posedge hclk);
    rd(CONTROL_IDX, 8'h81, 8'hff);
    rd(STATUS_IDX, 8'h80, 8'h80);
    wr(STATUS_IDX, 8'h08);
    @(posedge hclk);
    bump({6'h00, mo_o.oe_n, mi_o.oe_n}, 8'h01);
    $display("test mode fault and swap done");
    end_of_test;
  end
endmodule
